// file: core/cis_defs.vh
`ifndef CIS_DEFS_VH
`define CIS_DEFS_VH
// Register byte offsets on the Wishbone slave.
`define CIS_ADDR_W 4
`define CIS_OFF_INTSTAT 4'h0
`define CIS_OFF_TZSTAT 4'h4
`define CIS_OFF_PFLAG 4'h8
`define CIS_OFF_PEN 4'hc
// Interrupt status register fields.
`define CIS_B_EXT_EN 0
`define CIS_B_TZ_EN 1
`define CIS_B_TCK_EN 2
`define CIS_B_PER_EN 3
`define CIS_B_EXT_FL 4
`define CIS_B_TZ_FL 5
`define CIS_B_TCK_FL 6
`define CIS_B_PER_FL 7
// Timer zero status register fields.
`define CIS_B_INT_EDGE 7
`define CIS_B_TCK_EDGE 6
// Reset values, and the timer zero wrap compare values.
`define CIS_RST_8 8'h00
`define CIS_RST_4 4'h0
`define CIS_RST_1 1'b0
`define CIS_TZ_MAX 16'hffff
`define CIS_TZ_ZERO 16'h0000
`endif

// file: core/cis_edge.v
`timescale 1ns/100ps
`default_nettype none
module cis_edge (
   // Clock and reset.
   input wire i_clk,
   input wire i_rst_n,
   // Pin and edge choice.
   input wire i_pin,
   input wire i_rising,
   // Detected edge.
   output reg o_edge
);
   reg sync1_ff;
   reg sync2_ff;
   reg prev_ff;
   reg [2:0] arm_ff;
   // The history is unknown until the pin has filled the chain, so no edge is reported
   // before then; a pin idling high would otherwise look like a rising edge after reset.
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         prev_ff <= 1'b0;
         arm_ff <= 3'h0;
         o_edge <= 1'b0;
      end else begin
         sync1_ff <= i_pin;
         sync2_ff <= sync1_ff;
         prev_ff <= sync2_ff;
         arm_ff <= {arm_ff[1:0], 1'b1};
         o_edge <= arm_ff[2] & (i_rising ? (sync2_ff & ~prev_ff) : (~sync2_ff & prev_ff));
      end
   end
endmodule // cis_edge
`default_nettype wire

// file: core/cis_core.v
// Functional notes
// (RULE_01) External interrupt pin edge: rising when edge select is one, else falling.
// (RULE_02) A selected external pin edge sets the external interrupt flag, bit 4.
// (RULE_03) Clearing enable bit 0 suppresses the external pin interrupt.
// (RULE_04) An enabled external pin interrupt wakes the processor from sleep.
// (RULE_05) Timer zero rolling from ffff to 0000 sets overflow flag, bit 5.
// (RULE_06) Enable bit 1 enables or disables the timer zero overflow interrupt.
// (RULE_07) Timer clock pin edge: rising when its edge select is one, else falling.
// (RULE_08) A selected timer clock pin edge sets the timer clock flag, bit 6.
// (RULE_09) Clearing enable bit 2 suppresses the timer clock pin interrupt.
// (RULE_10) An enabled timer clock pin interrupt wakes the processor from sleep.
// (RULE_11) Peripheral summary flag is OR of peripheral flags ANDed with enables.
// (RULE_12) Only peripheral sources marked wake-capable may wake from sleep.
// (RULE_13) Wake by interrupt with global disable clear requests a vector load.
// (RULE_14) A wake by interrupt leaves its source flag set.
// (RULE_15) Flags stay set until software clears them; a new event wins a clear.
//
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`include "cis_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module cis_core (
   // Clock and reset.
   input wire i_clk,
   input wire i_resetn,
   // Wishbone slave.
   input wire i_wb_cyc,
   input wire i_wb_stb,
   input wire i_wb_we,
   input wire [3:0] i_wb_adr,
   input wire [3:0] i_wb_sel,
   input wire [31:0] i_wb_dat,
   output reg [31:0] o_wb_dat,
   output reg o_wb_ack,
   // External pins.
   input wire i_ext_int_pin,
   input wire i_timer_clock_pin,
   // Timer zero count and peripheral events from the same clock.
   input wire [15:0] i_timer_zero,
   input wire [7:0] i_periph_event,
   input wire [7:0] i_periph_wake_mask,
   // Core status.
   input wire i_sleeping,
   input wire i_global_interrupt_disable,
   // Interrupt and wake outputs.
   output reg o_irq,
   output reg o_wake,
   output reg o_vector_load
);
   reg rst1_ff;
   reg rst_n_ff;
   // Pins may toggle as reset lifts, so the block leaves reset on a clean clock edge.
   always @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst1_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end else begin
         rst1_ff <= 1'b1;
         rst_n_ff <= rst1_ff;
      end
   end

   // Register state.
   reg [3:0] int_en_ff;
   reg ext_fl_ff;
   reg tz_fl_ff;
   reg tck_fl_ff;
   reg per_fl_ff;
   reg [7:0] tzstat_ff;
   reg [7:0] pflag_ff;
   reg [7:0] pen_ff;
   reg [15:0] tz_prev_ff;
   wire [7:0] intstat;

   // Bus decode.
   wire bus_req;
   wire bus_commit;
   wire rd_take;
   wire wr;
   wire wr_int;
   wire wr_tz;
   wire wr_pf;
   wire wr_pe;
   wire [7:0] wdata;

   // Source events and requests.
   wire ext_edge;
   wire tck_edge;
   wire tz_ovf;
   wire [7:0] pactive;
   wire psum;
   wire ext_req;
   wire tz_req;
   wire tck_req;
   wire per_req;
   wire per_wake;
   wire wake_src;

   // Next-state values.
   wire [7:0] nxt_pflag;
   reg [3:0] nxt_int_en;
   reg nxt_ext_fl;
   reg nxt_tz_fl;
   reg nxt_tck_fl;
   reg nxt_per_fl;
   reg [7:0] nxt_tzstat;
   reg [7:0] nxt_pen;
   reg [31:0] nxt_rdata;
   reg nxt_ack;
   reg nxt_irq;
   reg nxt_wake;
   reg nxt_vector_load;

   cis_edge u_ext (
      .i_clk(i_clk),
      .i_rst_n(rst_n_ff),
      .i_pin(i_ext_int_pin),
      .i_rising(tzstat_ff[`CIS_B_INT_EDGE]), // RULE_01
      .o_edge(ext_edge)
   );

   cis_edge u_tck (
      .i_clk(i_clk),
      .i_rst_n(rst_n_ff),
      .i_pin(i_timer_clock_pin),
      .i_rising(tzstat_ff[`CIS_B_TCK_EDGE]), // RULE_07
      .o_edge(tck_edge)
   );

   // A write lands at the edge that samples ack high, while the master still holds it.
   assign bus_req = i_wb_cyc & i_wb_stb;
   assign bus_commit = bus_req & o_wb_ack;
   assign rd_take = bus_req & ~i_wb_we & ~o_wb_ack;
   assign wr = bus_commit & i_wb_we & i_wb_sel[0];
   assign wdata = i_wb_dat[7:0];
   assign wr_int = wr && (i_wb_adr == `CIS_OFF_INTSTAT);
   assign wr_tz = wr && (i_wb_adr == `CIS_OFF_TZSTAT);
   assign wr_pf = wr && (i_wb_adr == `CIS_OFF_PFLAG);
   assign wr_pe = wr && (i_wb_adr == `CIS_OFF_PEN);

   assign intstat = {per_fl_ff, tck_fl_ff, tz_fl_ff, ext_fl_ff, int_en_ff};
   assign tz_ovf = (tz_prev_ff == `CIS_TZ_MAX) && (i_timer_zero == `CIS_TZ_ZERO); // RULE_05
   assign pactive = pflag_ff & pen_ff;
   assign psum = |pactive; // RULE_11

   // Each peripheral flag bit takes a write first; its event is ORed in after, so a set wins.
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_pflag
         assign nxt_pflag[gi] = (wr_pf ? wdata[gi] : pflag_ff[gi]) | i_periph_event[gi]; // RULE_15
      end
   endgenerate

   always @* begin
      nxt_pen = pen_ff;
      if (wr_pe) begin
         nxt_pen = wdata;
      end
   end

   always @* begin
      nxt_tzstat = tzstat_ff;
      if (wr_tz) begin
         nxt_tzstat = wdata;
      end
   end

   always @* begin
      nxt_int_en = int_en_ff;
      if (wr_int) begin
         nxt_int_en = wdata[`CIS_B_PER_EN:`CIS_B_EXT_EN];
      end
   end

   // Flags take a software write first; events are ORed in afterwards so a set beats a clear.
   always @* begin
      nxt_ext_fl = ext_fl_ff;
      if (wr_int) begin
         nxt_ext_fl = wdata[`CIS_B_EXT_FL];
      end
      nxt_ext_fl = nxt_ext_fl | ext_edge; // RULE_02 RULE_15
   end

   always @* begin
      nxt_tz_fl = tz_fl_ff;
      if (wr_int) begin
         nxt_tz_fl = wdata[`CIS_B_TZ_FL];
      end
      nxt_tz_fl = nxt_tz_fl | tz_ovf; // RULE_05 RULE_15
   end

   always @* begin
      nxt_tck_fl = tck_fl_ff;
      if (wr_int) begin
         nxt_tck_fl = wdata[`CIS_B_TCK_FL];
      end
      nxt_tck_fl = nxt_tck_fl | tck_edge; // RULE_08 RULE_15
   end

   // The summary bit is read-only and always recomputed.
   always @* begin
      nxt_per_fl = |(nxt_pflag & nxt_pen); // RULE_11
   end

   // Read data is registered in the cycle the request is taken and stands with ack.
   always @* begin
      nxt_rdata = 32'h00000000;
      if (rd_take) begin
         case (i_wb_adr)
            `CIS_OFF_INTSTAT: begin
               nxt_rdata = {24'h000000, intstat};
            end
            `CIS_OFF_TZSTAT: begin
               nxt_rdata = {24'h000000, tzstat_ff};
            end
            `CIS_OFF_PFLAG: begin
               nxt_rdata = {24'h000000, pflag_ff};
            end
            `CIS_OFF_PEN: begin
               nxt_rdata = {24'h000000, pen_ff};
            end
            default: begin
               nxt_rdata = 32'h00000000;
            end
         endcase
      end
   end

   always @* begin
      nxt_ack = bus_req & ~o_wb_ack;
   end

   assign ext_req = ext_fl_ff & int_en_ff[`CIS_B_EXT_EN]; // RULE_03
   assign tz_req = tz_fl_ff & int_en_ff[`CIS_B_TZ_EN]; // RULE_06
   assign tck_req = tck_fl_ff & int_en_ff[`CIS_B_TCK_EN]; // RULE_09
   assign per_req = psum & int_en_ff[`CIS_B_PER_EN];
   // The timer overflow cannot wake: the timer is assumed stopped in sleep.
   assign per_wake = |(pactive & i_periph_wake_mask) & int_en_ff[`CIS_B_PER_EN]; // RULE_12
   assign wake_src = ext_req | tck_req | per_wake; // RULE_04 RULE_10 RULE_14

   always @* begin
      nxt_irq = ext_req | tz_req | tck_req | per_req;
      nxt_wake = i_sleeping & wake_src; // RULE_04 RULE_10 RULE_12
      nxt_vector_load = i_sleeping & wake_src & ~i_global_interrupt_disable; // RULE_13
   end

   always @(posedge i_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         int_en_ff <= `CIS_RST_4;
      end else begin
         int_en_ff <= nxt_int_en;
      end
   end

   always @(posedge i_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         ext_fl_ff <= `CIS_RST_1;
      end else begin
         ext_fl_ff <= nxt_ext_fl;
      end
   end

   always @(posedge i_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         tz_fl_ff <= `CIS_RST_1;
      end else begin
         tz_fl_ff <= nxt_tz_fl;
      end
   end

   always @(posedge i_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         tck_fl_ff <= `CIS_RST_1;
      end else begin
         tck_fl_ff <= nxt_tck_fl;
      end
   end

   always @(posedge i_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         per_fl_ff <= `CIS_RST_1;
      end else begin
         per_fl_ff <= nxt_per_fl;
      end
   end

   always @(posedge i_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         tzstat_ff <= `CIS_RST_8;
      end else begin
         tzstat_ff <= nxt_tzstat;
      end
   end

   always @(posedge i_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         pflag_ff <= `CIS_RST_8;
      end else begin
         pflag_ff <= nxt_pflag;
      end
   end

   always @(posedge i_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         pen_ff <= `CIS_RST_8;
      end else begin
         pen_ff <= nxt_pen;
      end
   end

   always @(posedge i_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         tz_prev_ff <= `CIS_TZ_ZERO;
      end else begin
         tz_prev_ff <= i_timer_zero;
      end
   end

   always @(posedge i_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         o_wb_ack <= 1'b0;
      end else begin
         o_wb_ack <= nxt_ack;
      end
   end

   always @(posedge i_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         o_wb_dat <= 32'h00000000;
      end else begin
         o_wb_dat <= nxt_rdata;
      end
   end

   always @(posedge i_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= nxt_irq;
      end
   end

   always @(posedge i_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         o_wake <= 1'b0;
      end else begin
         o_wake <= nxt_wake;
      end
   end

   always @(posedge i_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         o_vector_load <= 1'b0;
      end else begin
         o_vector_load <= nxt_vector_load;
      end
   end
endmodule // cis_core
`default_nettype wire

// file: tb/cis_checker.sv
`timescale 1ns/100ps
`default_nettype none
module cis_checker (
   input wire logic i_clk, i_resetn, i_wb_cyc, i_wb_stb, i_wb_we,
   input wire logic [3:0] i_wb_adr,
   input wire logic [31:0] o_wb_dat,
   input wire logic o_wb_ack, i_sleeping, i_global_interrupt_disable,
   input wire logic o_irq, o_wake, o_vector_load
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   wire logic q = i_wb_cyc & i_wb_stb;
   ack_next_a: assert property (q & !o_wb_ack |=> o_wb_ack) else $error("no ack");
   ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("long ack");
   ack_cause_a: assert property (o_wb_ack |-> $past(q)) else $error("stray ack");
   dat_high_a: assert property (o_wb_ack |-> o_wb_dat[31:8] == 0) else $error("high data");
   dat_hole_a: assert property (o_wb_ack && $past(i_wb_adr[1:0] != 0 && !i_wb_we)
      |-> o_wb_dat == 0) else $error("hole data");
   wake_sleep_a: assert property (o_wake |-> $past(i_sleeping)) else $error("bad wake");
   vec_gate_a: assert property (o_vector_load |->
      !$past(i_global_interrupt_disable) && (o_wake || $past(o_wake))) else $error("bad vector");
   irq_hold_a: assert property ($fell(o_irq) |->
      $past(o_wb_ack) || $past(o_wb_ack, 2) || $past(o_wb_ack, 3)) else $error("irq fell");
   irq_c: cover property (o_irq);
   wake_c: cover property (o_wake);
   vec_c: cover property (o_vector_load);
endmodule // cis_checker
bind cis_core cis_checker u_chk (.i_clk, .i_resetn, .i_wb_cyc, .i_wb_stb, .i_wb_we,
   .i_wb_adr, .o_wb_dat, .o_wb_ack, .i_sleeping, .i_global_interrupt_disable, .o_irq,
   .o_wake, .o_vector_load);
`default_nettype wire

// file: tb/cis_pins.sv
`timescale 1ns/100ps
`default_nettype none
module cis_pins (
   input wire logic i_clk,
   input wire logic [1:0] i_lvl,
   output var logic [1:0] o_pin = 2'h0
);
   // Pins move once a cycle only; the design must still treat them as unsynchronised.
   always @(posedge i_clk) o_pin <= i_lvl;
endmodule // cis_pins
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk = '0, rst_n = '0, cyc = '0, stb = '0, we = '0, sl = '0, gid = '0;
   logic [3:0] adr = '0;
   logic [7:0] wd = '0, pev = '0, msk = 8'h04;
   logic [15:0] tz = '0;
   logic [1:0] lvl = '0, pin;
   logic [31:0] rd, got;
   logic ack, irq, wake, vl;
   int fails = 0, n_tests = 0, k;
   initial forever #4 clk = ~clk;
   cis_pins u_pins (.i_clk(clk), .i_lvl(lvl), .o_pin(pin));
   cis_core u_dut (.i_clk(clk), .i_resetn(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat({24'h0, wd}),
      .o_wb_dat(rd), .o_wb_ack(ack), .i_ext_int_pin(pin[0]), .i_timer_clock_pin(pin[1]),
      .i_timer_zero(tz), .i_periph_event(pev), .i_periph_wake_mask(msk), .i_sleeping(sl),
      .i_global_interrupt_disable(gid), .o_irq(irq), .o_wake(wake), .o_vector_load(vl));
   task wrap_up;
      $display("tests %0d fails %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task cmp(input string nm, input logic [31:0] e, s);
      n_tests++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %s exp %h got %h", nm, e, s);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Read data is taken at the ack edge, before that edge's updates land.
   task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      {cyc, stb, we, adr, wd} <= {2'h3, w, a, d};
      k = 0;
      do begin tick(1); k++; end while (ack !== 1'h1 && k < 20);
      got = rd;
      cyc <= 1'h0;
      stb <= 1'h0;
      if (k == 20) begin fails++; wrap_up; end
      tick(1);
   endtask
   task rdc(input logic [3:0] a, input logic [31:0] e, input string nm);
      bus(1'h0, a, 8'h00);
      cmp(nm, e, got);
   endtask
   task t_pin(input int b);
      logic [7:0] f, en;
      f = 8'h10 << 2 * b;
      en = 8'h01 << 2 * b;
      bus(1'h1, 4'h4, 8'h00);
      lvl[b] <= 1'h1; tick(8); rdc(4'h0, 0, "no rise");
      lvl[b] <= 1'h0; tick(8); rdc(4'h0, f, "fall");
      cmp("irq off", 0, irq);
      bus(1'h1, 4'h0, f | en); tick(2); cmp("irq on", 1, irq);
      sl <= 1'h1; tick(3); cmp("wake", 2'h3, {wake, vl});
      sl <= 1'h0; bus(1'h1, 4'h4, 8'h80 >> b); lvl[b] <= 1'h1; tick(8);
      rdc(4'h0, f | en, "keep");
      bus(1'h1, 4'h0, en); lvl[b] <= 1'h0; tick(8);
      rdc(4'h0, en, "no fall");
      lvl[b] <= 1'h1; tick(8); rdc(4'h0, f | en, "rise");
      lvl[b] <= 1'h0; tick(8); bus(1'h1, 4'h0, 8'h00);
      $display("pin %0d done", b);
   endtask
   task t_tz;
      tz <= 16'hffff; tick(2); rdc(4'h0, 0, "max");
      tz <= 16'h0000; tick(2); rdc(4'h0, 8'h20, "wrap");
      cmp("tz off", 0, irq);
      bus(1'h1, 4'h0, 8'h22); tick(2); cmp("tz on", 1, irq);
      bus(1'h1, 4'h0, 8'h00);
      $display("timer done");
   endtask
   task t_per;
      bus(1'h1, 4'hc, 8'h04); bus(1'h1, 4'h0, 8'h08);
      pev <= 8'h06; tick(1); pev <= 8'h00; tick(2);
      rdc(4'h8, 8'h06, "pflag");
      rdc(4'h0, 8'h88, "summary");
      gid <= 1'h1; sl <= 1'h1; tick(3); cmp("per wake", 2'h2, {wake, vl});
      msk <= 8'h02; tick(3); cmp("masked", 0, wake);
      sl <= 1'h0; rdc(4'h8, 8'h06, "source");
      bus(1'h1, 4'hc, 8'h00); rdc(4'h0, 8'h08, "no sum");
      rdc(4'h2, 0, "hole");
      $display("peripheral done");
   endtask
   initial begin
      tick(6);
      rst_n <= 1'h1;
      tick(3);
      t_pin(0);
      t_pin(1);
      t_tz;
      t_per;
      wrap_up;
   end
endmodule // testbench
`default_nettype wire
